// [logic/sfm_mapper.sv]
// Slot frame to VC-4 payload mapper, source and sink directions.
// Assumes one octet per clock on the path side and a slot switch that
// offers slots with a valid and ready handshake.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defs.svh"
module sfm_mapper
    import sfm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Source slots from the switch
    input wire logic tx_slot_valid,
    input wire sfm_kind_t tx_slot_kind,
    input wire logic [63:0] tx_slot_data,
    output logic tx_slot_ready,
    input wire logic frame_start_strobe,
    // Source octets toward the path
    output logic [7:0] tx_octet,
    output logic tx_octet_valid,
    output logic tx_frame_start,
    // Sink octets from the path
    input wire logic [7:0] rx_octet,
    input wire logic rx_octet_valid,
    input wire logic rx_frame_start,
    input wire logic trail_fail_indication,
    input wire logic port_inactive_state,
    // Sink slots toward the switch
    output logic rx_slot_valid,
    output sfm_kind_t rx_slot_kind,
    output logic [63:0] rx_slot_data,
    output logic rx_slot_frame_start,
    // Supervision
    output logic server_fail_indication,
    output logic port_fail_indication,
    output logic label_mismatch,
    output logic alarm_insert_active
);
    function automatic logic [64:0] sfm_encode(input sfm_kind_t kind,
                                              input logic [63:0] data);
        case (kind)
            SFM_KIND_DATA: sfm_encode = {1'b0, data};
            SFM_KIND_IDLE: sfm_encode = {1'b1, `SFM_CODE_IDLE, 56'h0};
            SFM_KIND_PERF: sfm_encode = {1'b1, `SFM_CODE_PERF, data[55:0]};
            default: sfm_encode = {1'b1, `SFM_CODE_ALARM, 56'h0};
        endcase
    endfunction

    function automatic logic [7:0] sfm_poh(input sfm_row_t row);
        case (row)
            `SFM_ROW_C2: sfm_poh = `SFM_C2_LABEL;
            default: sfm_poh = `SFM_UNUSED_OH;
        endcase
    endfunction

    // Source side.
    logic [11:0] frame_timer_q;
    logic frame_go;
    sfm_row_t tx_row;
    sfm_col_t tx_col;
    logic tx_active;
    logic [64:0] hold_q;
    logic hold_full_q;
    logic hold_full_d;
    logic ready_q;
    logic accept;
    logic tx_pay;
    logic need_word;
    logic [71:0] tx_acc_q;
    logic [71:0] tx_acc_d;
    logic [6:0] tx_cnt_q;
    logic [6:0] tx_cnt_d;
    logic [71:0] tx_shift;
    logic [7:0] tx_raw;
    logic [7:0] tx_scr;
    logic [7:0] tx_octet_q;
    logic tx_valid_q;
    logic tx_fs_q;

    // A missing strobe does not stall the link: the timer starts the next
    // frame itself once a whole period has run out.
    assign frame_go = frame_start_strobe ||
        (frame_timer_q == 12'(`SFM_FRAME_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            frame_timer_q <= 12'h000;
        end else if (frame_go) begin
            frame_timer_q <= 12'h000;
        end else begin
            frame_timer_q <= frame_timer_q + 12'h001;
        end
    end

    sfm_vc_position u_tx_pos (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(frame_go),
        .advance(1'b1),
        .cur_row(tx_row),
        .cur_col(tx_col),
        .cur_active(tx_active)
    );

    assign accept = tx_slot_valid && ready_q;
    assign tx_pay = tx_active && (tx_col != 9'h000);
    assign need_word = tx_pay && (tx_cnt_q < `SFM_OCTET_BITS);

    always_comb begin
        hold_full_d = (hold_full_q && !need_word) || accept;
    end

    // One slot of holding keeps the ready port on a flop.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hold_q <= 65'h0;
            hold_full_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            if (accept) begin
                hold_q <= sfm_encode(tx_slot_kind, tx_slot_data);
            end
            hold_full_q <= hold_full_d;
            ready_q <= !hold_full_d;
        end
    end

    // Words are appended behind the leftover bits, so no gap ever opens.
    always_comb begin
        tx_acc_d = tx_acc_q;
        tx_cnt_d = frame_go ? 7'h00 : tx_cnt_q;
        tx_raw = 8'h00;
        tx_shift = 72'h0;
        if (tx_pay) begin
            if (tx_cnt_d < `SFM_OCTET_BITS) begin
                if (hold_full_q) begin
                    tx_acc_d = {tx_acc_q[6:0], hold_q};
                end else begin
                    tx_acc_d = {tx_acc_q[6:0],
                        sfm_encode(SFM_KIND_IDLE, 64'h0)};
                end
                tx_cnt_d = tx_cnt_d + `SFM_WORD_BITS;
            end
            tx_shift = tx_acc_d >> (tx_cnt_d - `SFM_OCTET_BITS);
            tx_raw = tx_shift[7:0];
            tx_cnt_d = tx_cnt_d - `SFM_OCTET_BITS;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_acc_q <= 72'h0;
            tx_cnt_q <= 7'h00;
        end else begin
            tx_acc_q <= tx_acc_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    sfm_scram #(
        .DESCRAMBLE(1'b0)
    ) u_scram (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(tx_pay),
        .in_octet(tx_raw),
        .out_octet(tx_scr)
    );

    // Overhead octets bypass the scrambler; only the payload is scrambled.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_octet_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_fs_q <= 1'b0;
        end else begin
            tx_valid_q <= tx_active;
            tx_fs_q <= frame_go;
            if (!tx_active) begin
                tx_octet_q <= 8'h00;
            end else if (tx_pay) begin
                tx_octet_q <= tx_scr;
            end else begin
                tx_octet_q <= sfm_poh(tx_row);
            end
        end
    end

    assign tx_slot_ready = ready_q;
    assign tx_octet = tx_octet_q;
    assign tx_octet_valid = tx_valid_q;
    assign tx_frame_start = tx_fs_q;

    // Sink side.
    sfm_row_t rx_row;
    sfm_col_t rx_col;
    logic rx_active;
    logic rx_restart;
    logic rx_pay;
    logic [7:0] rx_plain;
    logic [71:0] rx_acc_q;
    logic [71:0] rx_acc_d;
    logic [6:0] rx_cnt_q;
    logic [6:0] rx_cnt_d;
    logic [71:0] rx_shift;
    logic [64:0] rx_word;
    logic rx_word_ok;
    logic first_q;
    logic plm_q;
    logic alarm_marker;
    logic [7:0] rx_code;
    logic rx_slot_valid_q;
    sfm_kind_t rx_kind_q;
    logic [63:0] rx_data_q;
    logic rx_fs_q;
    logic ssf_q;
    logic tsf_q;
    logic cplm_q;
    logic ais_q;

    assign rx_restart = rx_octet_valid && rx_frame_start;

    sfm_vc_position u_rx_pos (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .restart(rx_restart),
        .advance(rx_octet_valid),
        .cur_row(rx_row),
        .cur_col(rx_col),
        .cur_active(rx_active)
    );

    assign rx_pay = rx_octet_valid && rx_active && (rx_col != 9'h000);

    sfm_scram #(
        .DESCRAMBLE(1'b1)
    ) u_descram (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(rx_pay),
        .in_octet(rx_octet),
        .out_octet(rx_plain)
    );

    // A word is complete once 65 bits are on hand; the rest stay queued.
    always_comb begin
        rx_acc_d = rx_acc_q;
        rx_cnt_d = rx_restart ? 7'h00 : rx_cnt_q;
        rx_word_ok = 1'b0;
        rx_word = 65'h0;
        rx_shift = 72'h0;
        if (rx_pay) begin
            rx_acc_d = {rx_acc_q[63:0], rx_plain};
            rx_cnt_d = rx_cnt_d + `SFM_OCTET_BITS;
            if (rx_cnt_d >= `SFM_WORD_BITS) begin
                rx_shift = rx_acc_d >> (rx_cnt_d - `SFM_WORD_BITS);
                rx_word = rx_shift[64:0];
                rx_word_ok = 1'b1;
                rx_cnt_d = rx_cnt_d - `SFM_WORD_BITS;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_acc_q <= 72'h0;
            rx_cnt_q <= 7'h00;
        end else begin
            rx_acc_q <= rx_acc_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // The label is judged once per frame and held until the next one.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            plm_q <= 1'b0;
        end else if (rx_octet_valid && rx_active && rx_col == 9'h000 &&
                     rx_row == `SFM_ROW_C2) begin
            plm_q <= (rx_octet != `SFM_C2_LABEL);
        end
    end

    assign alarm_marker = trail_fail_indication || plm_q ||
        port_inactive_state;
    assign rx_code = rx_word[63:56];

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            first_q <= 1'b0;
        end else if (rx_restart) begin
            first_q <= 1'b1;
        end else if (rx_word_ok) begin
            first_q <= 1'b0;
        end
    end

    // Unknown marker codes are passed up as alarms rather than as data.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_slot_valid_q <= 1'b0;
            rx_kind_q <= SFM_KIND_IDLE;
            rx_data_q <= 64'h0;
            rx_fs_q <= 1'b0;
        end else begin
            rx_slot_valid_q <= rx_word_ok;
            if (rx_word_ok) begin
                rx_fs_q <= first_q && !rx_restart;
                if (alarm_marker) begin
                    rx_kind_q <= SFM_KIND_ALARM;
                    rx_data_q <= {`SFM_CODE_ALARM, 56'h0};
                end else if (!rx_word[64]) begin
                    rx_kind_q <= SFM_KIND_DATA;
                    rx_data_q <= rx_word[63:0];
                end else if (rx_code == `SFM_CODE_IDLE) begin
                    rx_kind_q <= SFM_KIND_IDLE;
                    rx_data_q <= rx_word[63:0];
                end else if (rx_code == `SFM_CODE_PERF) begin
                    rx_kind_q <= SFM_KIND_PERF;
                    rx_data_q <= rx_word[63:0];
                end else begin
                    rx_kind_q <= SFM_KIND_ALARM;
                    rx_data_q <= rx_word[63:0];
                end
            end else begin
                rx_fs_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ssf_q <= 1'b0;
            tsf_q <= 1'b0;
            cplm_q <= 1'b0;
            ais_q <= 1'b0;
        end else begin
            ssf_q <= trail_fail_indication || plm_q;
            tsf_q <= alarm_marker;
            cplm_q <= plm_q && !trail_fail_indication;
            ais_q <= alarm_marker;
        end
    end

    assign rx_slot_valid = rx_slot_valid_q;
    assign rx_slot_kind = rx_kind_q;
    assign rx_slot_data = rx_data_q;
    assign rx_slot_frame_start = rx_fs_q;
    assign server_fail_indication = ssf_q;
    assign port_fail_indication = tsf_q;
    assign label_mismatch = cplm_q;
    assign alarm_insert_active = ais_q;
endmodule
`default_nettype wire

// [logic/sfm_defs.svh]
// Constants for the slot frame to VC-4 mapper: overhead layout, marker
// codes and frame timing.
// Assumes inclusion by name from every file that needs these values.
//
// Operation
// - One slot frame is handled every 125 us, that is 8000 per second.
// - A slot holds either 64 data bits or one of a few marker codes.
// - The source turns every slot, data or marker, into a 65-bit word.
// - The 65-bit words are packed back to back, locked to the frame.
// - The source scrambles the payload with a self-synchronous scrambler.
// - The sink descrambles, unpacks and decodes the words into slots.
// - Frame start travels beside the octets, never as an in-band code.
// - On a path alarm the sink puts alarm markers in place of slots.
// - The sink derives port availability from path supervision inputs.
// - A slot with no user data carries the idle marker.
// - The alarm marker fills data slots lost to a path defect.
// - The supervision marker carries per-channel supervision data.
// - Scrambler and descrambler use the polynomial x^43 + 1.
// - Each word goes out flag bit first, then data bits 63 down to 0.
// - The label octet is 00000101; F2, F3 and H4 are sent as zero.
// - Alarm insertion follows trail fail, label mismatch or inactivity.

`ifndef SFM_DEFS_SVH
`define SFM_DEFS_SVH

`define SFM_LAST_ROW 4'h8
`define SFM_LAST_COL 9'h104
`define SFM_ROW_C2 4'h2
`define SFM_ROW_F2 4'h4
`define SFM_ROW_H4 4'h5
`define SFM_ROW_F3 4'h6
`define SFM_C2_LABEL 8'h05
`define SFM_UNUSED_OH 8'h00
`define SFM_SCR_TAP 43
`define SFM_WORD_BITS 7'h41
`define SFM_OCTET_BITS 7'h08
`define SFM_CODE_IDLE 8'h01
`define SFM_CODE_PERF 8'h02
`define SFM_CODE_ALARM 8'h03
`define SFM_FRAME_PERIOD_NS 125000
`define SFM_CLK_PERIOD_NS 40
`define SFM_FRAME_CYCLES (`SFM_FRAME_PERIOD_NS / `SFM_CLK_PERIOD_NS)

`endif

// [logic/sfm_pkg.sv]
// Types shared by the slot frame to VC-4 mapper.
// Assumes nothing of its surroundings.
package sfm_pkg;

    typedef enum logic [1:0] {
        SFM_KIND_DATA,
        SFM_KIND_IDLE,
        SFM_KIND_PERF,
        SFM_KIND_ALARM
    } sfm_kind_t;

    typedef logic [3:0] sfm_row_t;
    typedef logic [8:0] sfm_col_t;

endpackage

// [logic/sfm_scram.sv]
// Self-synchronous octet scrambler or descrambler.
// Assumes octets arrive most significant bit first, one per valid cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defs.svh"
module sfm_scram #(
    parameter bit DESCRAMBLE = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Octet stream
    input wire logic in_valid,
    input wire logic [7:0] in_octet,
    output logic [7:0] out_octet
);
    logic [`SFM_SCR_TAP-1:0] state_q;
    logic [`SFM_SCR_TAP-1:0] state_d;

    // The state holds line bits on both ends, so they track each other.
    always_comb begin
        logic x;
        logic y;
        x = 1'b0;
        y = 1'b0;
        state_d = state_q;
        out_octet = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            x = in_octet[i];
            y = x ^ state_d[`SFM_SCR_TAP-1];
            out_octet[i] = y;
            state_d = {state_d[`SFM_SCR_TAP-2:0], DESCRAMBLE ? x : y};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_q <= '0;
        end else if (in_valid) begin
            state_q <= state_d;
        end
    end
endmodule
`default_nettype wire

// [logic/sfm_vc_position.sv]
// Row and column tracker of one VC-4 frame of 9 rows by 261 columns.
// Assumes restart marks the octet in column 0 of row 0.
`timescale 1ns/1ps
`default_nettype none
`include "sfm_defs.svh"
module sfm_vc_position
    import sfm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Control
    input wire logic restart,
    input wire logic advance,
    // Position of the current octet
    output sfm_row_t cur_row,
    output sfm_col_t cur_col,
    output logic cur_active
);
    sfm_row_t row_q;
    sfm_col_t col_q;
    logic active_q;

    assign cur_row = restart ? 4'h0 : row_q;
    assign cur_col = restart ? 9'h000 : col_q;
    assign cur_active = restart | active_q;

    // The frame stops at its last octet and waits for the next start.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            row_q <= 4'h0;
            col_q <= 9'h000;
            active_q <= 1'b0;
        end else if (advance && cur_active) begin
            active_q <= 1'b1;
            if (cur_col == `SFM_LAST_COL) begin
                col_q <= 9'h000;
                row_q <= cur_row + 4'h1;
                if (cur_row == `SFM_LAST_ROW) begin
                    row_q <= 4'h0;
                    active_q <= 1'b0;
                end
            end else begin
                col_q <= cur_col + 9'h001;
                row_q <= cur_row;
            end
        end else if (restart) begin
            row_q <= 4'h0;
            col_q <= 9'h000;
            active_q <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb/sfm_mapper_checker.sv]
// Port checks for the slot frame mapper, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfm_mapper_checker
    import sfm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Source side
    input wire logic tx_slot_valid,
    input wire logic tx_slot_ready,
    input wire logic frame_start_strobe,
    input wire logic [7:0] tx_octet,
    input wire logic tx_octet_valid,
    input wire logic tx_frame_start,
    // Sink side
    input wire logic trail_fail_indication,
    input wire logic port_inactive_state,
    input wire logic rx_slot_valid,
    input wire sfm_kind_t rx_slot_kind,
    input wire logic server_fail_indication,
    input wire logic port_fail_indication,
    input wire logic label_mismatch,
    input wire logic alarm_insert_active
);
    // Counters too long for a repetition: octet index and frame gap.
    logic [11:0] pos_q;
    logic [12:0] gap_q;
    logic mid_frame;
    assign mid_frame = tx_octet_valid && !tx_frame_start;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || tx_frame_start) begin
            pos_q <= 12'h000;
        end else if (tx_octet_valid) begin
            pos_q <= pos_q + 12'h001;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n || tx_frame_start) begin
            gap_q <= 13'h0000;
        end else begin
            gap_q <= gap_q + 13'h0001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_slot_taken;
        tx_slot_valid && tx_slot_ready;
    endsequence
    sequence s_j1_out;
        tx_frame_start && tx_octet_valid && tx_octet == 8'h00;
    endsequence
    a_start_answer: assert property (frame_start_strobe |=> s_j1_out)
        else $error("frame start octet missing");
    a_slot_handshake: assert property (s_slot_taken |=> !tx_slot_ready)
        else $error("ready stayed high after take");
    a_label_octet: assert property (mid_frame && pos_q == 12'h209 |-> tx_octet == 8'h05)
        else $error("wrong label octet");
    a_unused_octets: assert property (mid_frame && (pos_q == 12'h413
        || pos_q == 12'h518 || pos_q == 12'h61d) |-> tx_octet == 8'h00)
        else $error("unused overhead not zero");
    a_frame_length: assert property ($fell(tx_octet_valid) |-> pos_q == 12'h92c)
        else $error("frame length wrong");
    a_frame_period: assert property (gap_q <= 13'h0c35)
        else $error("frame period exceeded");
    a_alarm_subst: assert property (rx_slot_valid && ($past(trail_fail_indication)
        || $past(port_inactive_state)) |-> rx_slot_kind == SFM_KIND_ALARM)
        else $error("slot not replaced by alarm");
    a_server_fail: assert property (server_fail_indication
        == ($past(trail_fail_indication) || label_mismatch))
        else $error("server fail wrong");
    a_port_fail: assert property (port_fail_indication
        == (server_fail_indication || $past(port_inactive_state)))
        else $error("port fail wrong");
    a_alarm_insert: assert property (alarm_insert_active == port_fail_indication)
        else $error("alarm insert wrong");
    a_mismatch_masked: assert property ($past(trail_fail_indication) |-> !label_mismatch)
        else $error("mismatch shown under trail fail");
    a_slot_pulse: assert property (rx_slot_valid |=> !rx_slot_valid)
        else $error("slot valid longer than one cycle");
endmodule
bind sfm_mapper sfm_mapper_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .tx_slot_valid(tx_slot_valid), .tx_slot_ready(tx_slot_ready),
    .frame_start_strobe(frame_start_strobe), .tx_octet(tx_octet),
    .tx_octet_valid(tx_octet_valid), .tx_frame_start(tx_frame_start),
    .trail_fail_indication(trail_fail_indication),
    .port_inactive_state(port_inactive_state), .rx_slot_valid(rx_slot_valid),
    .rx_slot_kind(rx_slot_kind), .server_fail_indication(server_fail_indication),
    .port_fail_indication(port_fail_indication), .label_mismatch(label_mismatch),
    .alarm_insert_active(alarm_insert_active));
`default_nettype wire

// [tb/sfm_path_model.sv]
// Path model: carries source octets back to the sink one cycle later.
// Assumes the mapper's own octet and frame start outputs as its input.
`timescale 1ns/1ps
`default_nettype none
module sfm_path_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Octets from the source
    input wire logic [7:0] tx_octet,
    input wire logic tx_octet_valid,
    input wire logic tx_frame_start,
    // Commanded fault: a wrong signal label
    input wire logic bad_label,
    // Octets toward the sink
    output logic [7:0] rx_octet,
    output logic rx_octet_valid,
    output logic rx_frame_start
);
    logic [11:0] pos_q;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || tx_frame_start) begin
            pos_q <= 12'h000;
        end else if (tx_octet_valid) begin
            pos_q <= pos_q + 12'h001;
        end
    end
    // Outside frames the octet toggles so a stale value is never trusted.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_octet <= 8'h00;
            rx_octet_valid <= 1'b0;
            rx_frame_start <= 1'b0;
        end else begin
            rx_octet_valid <= tx_octet_valid;
            rx_frame_start <= tx_frame_start && tx_octet_valid;
            if (!tx_octet_valid) begin
                rx_octet <= ~rx_octet;
            end else if (bad_label && !tx_frame_start && pos_q == 12'h209) begin
                rx_octet <= 8'h0a;
            end else begin
                rx_octet <= tx_octet;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the slot frame mapper in path loopback.
// Assumes the path model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb import sfm_pkg::*;;
    logic clk_sys, reset_n, tx_slot_valid, tx_slot_ready, frame_start_strobe;
    logic tx_octet_valid, tx_frame_start, rx_octet_valid, rx_frame_start;
    logic trail_fail_indication, port_inactive_state, bad_label, rx_slot_valid;
    logic server_fail_indication, port_fail_indication, label_mismatch;
    logic alarm_insert_active, rx_slot_frame_start;
    logic [7:0] tx_octet, rx_octet;
    logic [63:0] tx_slot_data, rx_slot_data;
    logic [31:0] r;
    sfm_kind_t tx_slot_kind, rx_slot_kind;
    sfm_kind_t exp_kind[$];
    logic [63:0] exp_data[$];
    integer fail_count, tests_run, seed, idle_seen, i, mon_mode, fs_seen = 0;
    sfm_mapper u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .tx_slot_valid(tx_slot_valid), .tx_slot_kind(tx_slot_kind),
        .tx_slot_data(tx_slot_data), .tx_slot_ready(tx_slot_ready),
        .frame_start_strobe(frame_start_strobe), .tx_octet(tx_octet),
        .tx_octet_valid(tx_octet_valid), .tx_frame_start(tx_frame_start),
        .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid),
        .rx_frame_start(rx_frame_start),
        .trail_fail_indication(trail_fail_indication),
        .port_inactive_state(port_inactive_state), .rx_slot_valid(rx_slot_valid),
        .rx_slot_kind(rx_slot_kind), .rx_slot_data(rx_slot_data),
        .rx_slot_frame_start(rx_slot_frame_start),
        .server_fail_indication(server_fail_indication),
        .port_fail_indication(port_fail_indication),
        .label_mismatch(label_mismatch),
        .alarm_insert_active(alarm_insert_active));
    sfm_path_model u_path (.clk_sys(clk_sys), .reset_n(reset_n),
        .tx_octet(tx_octet), .tx_octet_valid(tx_octet_valid),
        .tx_frame_start(tx_frame_start), .bad_label(bad_label),
        .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid),
        .rx_frame_start(rx_frame_start));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Marker words carry their code in the top octet.
    function automatic logic [63:0] expect_word(input sfm_kind_t k,
                                                input logic [63:0] d);
        case (k)
            SFM_KIND_DATA: expect_word = d;
            SFM_KIND_PERF: expect_word = {8'h02, d[55:0]};
            SFM_KIND_IDLE: expect_word = {8'h01, 56'h0};
            default: expect_word = {8'h03, 56'h0};
        endcase
    endfunction
    // Idle slots are not queued: the source may add filler idles of its own.
    task automatic send_slot(input sfm_kind_t k, input logic [63:0] d);
        integer n;
        n = 0;
        tx_slot_valid <= 1'b1;
        tx_slot_kind <= k;
        tx_slot_data <= d;
        @(posedge clk_sys);
        while (tx_slot_ready !== 1'b1 && n < 4000) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        if (k != SFM_KIND_IDLE) begin
            exp_kind.push_back(k);
            exp_data.push_back(d);
        end
    endtask
    always @(posedge clk_sys) begin
        if (rx_slot_valid === 1'b1 && mon_mode == 2) begin
            chk("alarm kind", SFM_KIND_ALARM, rx_slot_kind);
        end else if (rx_slot_valid === 1'b1 && mon_mode == 1) begin
            if (rx_slot_frame_start === 1'b1) fs_seen = fs_seen + 1;
            if (rx_slot_kind === SFM_KIND_IDLE) begin
                idle_seen = idle_seen + 1;
            end else if (exp_kind.size() == 0) begin
                chk("spare slot", SFM_KIND_IDLE, rx_slot_kind);
            end else begin
                chk("slot kind", exp_kind[0], rx_slot_kind);
                if (exp_kind[0] != SFM_KIND_ALARM) begin
                    chk("slot data", expect_word(exp_kind[0], exp_data[0]), rx_slot_data);
                end
                exp_kind.pop_front();
                exp_data.pop_front();
            end
        end
    end
    initial begin
        #2000000;
        fail_count = fail_count + 1;
        print_verdict();
    end
    initial begin
        seed = 36013;
        fail_count = 0;
        tests_run = 0;
        idle_seen = 0;
        mon_mode = 0;
        reset_n = 1'b0;
        tx_slot_valid = 1'b0;
        tx_slot_kind = SFM_KIND_IDLE;
        tx_slot_data = 64'h0;
        frame_start_strobe = 1'b0;
        trail_fail_indication = 1'b0;
        port_inactive_state = 1'b0;
        bad_label = 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        mon_mode <= 1;
        @(posedge clk_sys);
        frame_start_strobe <= 1'b1;
        @(posedge clk_sys);
        frame_start_strobe <= 1'b0;
        send_slot(SFM_KIND_DATA, 64'hffffffffffffffff);
        send_slot(SFM_KIND_DATA, 64'h0);
        send_slot(SFM_KIND_IDLE, 64'h0);
        send_slot(SFM_KIND_PERF, 64'h00ffffffffffffff);
        send_slot(SFM_KIND_ALARM, 64'h0);
        for (i = 0; i < 320; i++) begin
            r = $random(seed);
            send_slot(sfm_kind_t'(r[1:0]), {$random(seed), $random(seed)});
        end
        tx_slot_valid <= 1'b0;
        for (i = 0; i < 8000 && exp_kind.size() > 0; i++) @(posedge clk_sys);
        chk("slots left", 64'h0, 64'(exp_kind.size()));
        chk("idle seen", 64'h1, 64'(idle_seen > 0));
        chk("frame start", 64'h1, 64'(fs_seen > 0));
        for (i = 0; i < 2; i++) begin
            mon_mode <= 0;
            trail_fail_indication <= (i == 0);
            port_inactive_state <= (i == 1);
            repeat (20) @(posedge clk_sys);
            mon_mode <= 2;
            repeat (800) @(posedge clk_sys);
            chk("server fail", 64'(i == 0), server_fail_indication);
            chk("port fail", 64'h1, port_fail_indication);
            mon_mode <= 0;
            trail_fail_indication <= 1'b0;
            port_inactive_state <= 1'b0;
            repeat (20) @(posedge clk_sys);
        end
        bad_label <= 1'b1;
        repeat (6300) @(posedge clk_sys);
        mon_mode <= 2;
        repeat (500) @(posedge clk_sys);
        chk("label mismatch", 64'h1, label_mismatch);
        chk("alarm insert", 64'h1, alarm_insert_active);
        mon_mode <= 0;
        bad_label <= 1'b0;
        repeat (6300) @(posedge clk_sys);
        chk("label clear", 64'h0, label_mismatch);
        print_verdict();
    end
endmodule
`default_nettype wire
